// *** hw/fleuc_pkg.sv ***
package fleuc_pkg;
  // register word byte addresses
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PAGE = 4'h8;
  localparam logic [3:0] ADDR_PROT = 4'hC;
  // command bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // status field positions
  localparam int ST_LOCK_HI = 1;
  localparam int ST_PAGE_BUSY = 2;
  localparam int ST_MASS_BUSY = 3;
  localparam int ST_REFUSED = 4;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    FLEUC_LOCKED = 3'b000,
    FLEUC_FIRST = 3'b001,
    FLEUC_UNLOCKED = 3'b011,
    FLEUC_PAGE_ERASE = 3'b010,
    FLEUC_MASS_ERASE = 3'b110
  } fleuc_state_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } fleuc_mem_type;
endpackage

// *** hw/fleuc_top.sv ***
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module fleuc_top #(
  parameter int PAGE_BYTES = 512,
  parameter int PAGES = 4,
  parameter int SECTORS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // access mode and option bits
  input wire logic dbg_access,
  input wire logic write_protect_opt,
  input wire logic read_protect_opt,
  input wire logic bypass_en,
  input wire logic [fleuc_pkg::ST_PAGE_BUSY:0] bypass_ctl,
  // program requests from the core
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  // flash array and core
  output fleuc_pkg::fleuc_mem_type mem_q,
  output logic core_stall,
  output logic [fleuc_pkg::ST_PAGE_BUSY:0] bypass_pins
);
  localparam int AW = $clog2(PAGE_BYTES * PAGES);
  localparam int OW = $clog2(PAGE_BYTES);
  localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1;
  localparam int SPP = (PAGES + SECTORS - 1) / SECTORS;

  fleuc_pkg::fleuc_state_type st_q, st_d;
  logic [AW-1:0] cnt_q, cnt_d;
  logic [PW-1:0] page_q, page_d;
  logic page_armed_q, page_armed_d;
  logic [SECTORS-1:0] prot_q, prot_d;
  logic refused_q, refused_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  fleuc_pkg::fleuc_mem_type mem_d;
  logic stall_q, stall_d;
  logic [fleuc_pkg::ST_PAGE_BUSY:0] byp_q, byp_d;

  function automatic logic is_prot(input logic [PW-1:0] pg, input logic [SECTORS-1:0] pr,
                                   input logic dbg, input logic wp);
    if (dbg) begin
      return 1'b0;
    end
    return wp | pr[32'(pg) / SPP];
  endfunction

  function automatic logic [31:0] addr_of(input logic [PW-1:0] pg, input logic [AW-1:0] off);
    return 32'(pg) * PAGE_BYTES + 32'(off);
  endfunction

  logic acc;
  logic wr;
  logic [7:0] cmd;
  logic busy;
  logic [PW-1:0] prog_page;
  assign acc = (avs_read | avs_write) & wait_q;
  assign wr = avs_write & wait_q;
  assign cmd = avs_writedata[7:0];
  assign busy = (st_q == fleuc_pkg::FLEUC_PAGE_ERASE) || (st_q == fleuc_pkg::FLEUC_MASS_ERASE);
  assign prog_page = PW'(prog_addr[AW-1:0] >> OW);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    page_d = page_q;
    page_armed_d = page_armed_q;
    prot_d = prot_q;
    refused_d = refused_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    mem_d = '0;
    stall_d = 1'b0;
    byp_d = '0;
    if (acc) begin
      wait_d = 1'b0;
    end
    // command register
    if (wr && avs_address == fleuc_pkg::ADDR_CMD && !busy) begin
      // the unlock bytes must pass, or mass erase could never be reached
      if (read_protect_opt && !(cmd == fleuc_pkg::CMD_MASS_ERASE
          || cmd == fleuc_pkg::CMD_UNLOCK1 || cmd == fleuc_pkg::CMD_UNLOCK2)) begin
        refused_d = 1'b1;
        st_d = fleuc_pkg::FLEUC_LOCKED;
      end else begin
        unique case (st_q)
          fleuc_pkg::FLEUC_LOCKED: begin
            if (cmd == fleuc_pkg::CMD_UNLOCK1) begin
              st_d = fleuc_pkg::FLEUC_FIRST;
            end
          end
          fleuc_pkg::FLEUC_FIRST: begin
            st_d = (cmd == fleuc_pkg::CMD_UNLOCK2) ? fleuc_pkg::FLEUC_UNLOCKED
                                                    : fleuc_pkg::FLEUC_LOCKED;
            page_armed_d = dbg_access;
          end
          default: begin
            if (cmd == fleuc_pkg::CMD_PAGE_ERASE && page_armed_q && !read_protect_opt) begin
              if (is_prot(page_q, prot_q, dbg_access, write_protect_opt)) begin
                refused_d = 1'b1;
                st_d = fleuc_pkg::FLEUC_LOCKED;
              end else begin
                st_d = fleuc_pkg::FLEUC_PAGE_ERASE;
                cnt_d = '0;
              end
            end else if (cmd == fleuc_pkg::CMD_MASS_ERASE && dbg_access) begin
              st_d = fleuc_pkg::FLEUC_MASS_ERASE;
              cnt_d = '0;
            end else begin
              refused_d = 1'b1;
              st_d = fleuc_pkg::FLEUC_LOCKED;
            end
          end
        endcase
      end
    end
    // page select: second write after unlock arms it, debug may rewrite
    if (wr && avs_address == fleuc_pkg::ADDR_PAGE && !busy && !read_protect_opt) begin
      if (st_q == fleuc_pkg::FLEUC_LOCKED) begin
        page_d = avs_writedata[PW-1:0];
      end else if (st_q == fleuc_pkg::FLEUC_UNLOCKED && (!page_armed_q || dbg_access)) begin
        page_armed_d = page_armed_q | (avs_writedata[PW-1:0] == page_q);
        if (dbg_access) begin
          page_d = avs_writedata[PW-1:0];
        end
      end
    end
    if (wr && avs_address == fleuc_pkg::ADDR_PROT && !busy) begin
      // protection only ever grows outside debug access
      prot_d = dbg_access ? avs_writedata[SECTORS-1:0]
                          : prot_q | avs_writedata[SECTORS-1:0];
    end
    if (wr && avs_address == fleuc_pkg::ADDR_STATUS) begin
      refused_d = 1'b0;
    end
    if (acc && avs_read) begin
      unique case (avs_address)
        fleuc_pkg::ADDR_CMD: rdata_d = fleuc_pkg::UNMAPPED_DATA;
        fleuc_pkg::ADDR_STATUS: rdata_d = {27'h0, refused_q,
                                           st_q == fleuc_pkg::FLEUC_MASS_ERASE,
                                           st_q == fleuc_pkg::FLEUC_PAGE_ERASE,
                                           st_q[1:0]};
        fleuc_pkg::ADDR_PAGE: rdata_d = 32'(page_q);
        fleuc_pkg::ADDR_PROT: rdata_d = 32'(prot_q);
        default: rdata_d = fleuc_pkg::UNMAPPED_DATA;
      endcase
    end
    // core programming into the open page, or into any page under debug access
    if (st_q == fleuc_pkg::FLEUC_UNLOCKED && prog_req && page_armed_q && !bypass_en
        && (dbg_access || prog_page == page_q)) begin
      mem_d.we = !is_prot(prog_page, prot_q, dbg_access, write_protect_opt);
      mem_d.addr = prog_addr;
      mem_d.data = prog_data;
    end
    // erase engines
    if (busy) begin
      stall_d = 1'b1;
      mem_d.we = !bypass_en;
      mem_d.data = fleuc_pkg::ERASED_BYTE;
      cnt_d = AW'(cnt_q + 1'b1);
      if (st_q == fleuc_pkg::FLEUC_PAGE_ERASE) begin
        mem_d.addr = 16'(addr_of(page_q, cnt_q));
        if (cnt_q[OW-1:0] == OW'(PAGE_BYTES - 1)) begin
          st_d = fleuc_pkg::FLEUC_LOCKED;
          page_armed_d = 1'b0;
        end
      end else begin
        mem_d.addr = 16'(cnt_q);
        if (cnt_q == AW'(PAGE_BYTES * PAGES - 1)) begin
          st_d = fleuc_pkg::FLEUC_LOCKED;
          page_armed_d = 1'b0;
        end
      end
    end
    if (st_q == fleuc_pkg::FLEUC_LOCKED) begin
      page_armed_d = 1'b0;
    end
    if (bypass_en) begin
      byp_d = bypass_ctl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= fleuc_pkg::FLEUC_LOCKED;
      cnt_q <= '0;
      page_q <= '0;
      page_armed_q <= 1'b0;
      prot_q <= '0;
      refused_q <= 1'b0;
      rdata_q <= '0;
      wait_q <= 1'b1;
      mem_q <= '0;
      stall_q <= 1'b0;
      byp_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      page_q <= page_d;
      page_armed_q <= page_armed_d;
      prot_q <= prot_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      mem_q <= mem_d;
      stall_q <= stall_d;
      byp_q <= byp_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign core_stall = stall_q;
  assign bypass_pins = byp_q;
endmodule

// *** verif/fleuc_properties.sv ***
`timescale 1ns/1ps
module fleuc_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bypass_en,
  input wire logic [2:0] bypass_ctl,
  input wire fleuc_pkg::fleuc_mem_type mem_q,
  input wire logic core_stall,
  input wire logic [2:0] bypass_pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ans_one_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  ans_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  idle_wait_a: assert property (!(avs_read | avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  pins_follow_a: assert property (bypass_en |=> bypass_pins == $past(bypass_ctl))
    else $error("bypass pins wrong");
  pins_off_a: assert property (!bypass_en |=> bypass_pins == 3'h0)
    else $error("bypass pins driven");
  erase_ones_a: assert property (core_stall && mem_q.we |-> mem_q.data == 8'hFF)
    else $error("erase byte not ones");
  stall_hold_a: assert property ($rose(core_stall) |-> core_stall [*8])
    else $error("stall too short");
endmodule

// *** verif/fleuc_flash_model.sv ***
`timescale 1ns/1ps
module fleuc_flash_model #(parameter int BYTES = 2048) (
  // clock and array write port
  input wire logic clk,
  input wire fleuc_pkg::fleuc_mem_type mem_q
);
  logic [7:0] mem [BYTES];
  // starts cleared so that an erase shows
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge clk) begin
    if (mem_q.we && mem_q.addr < BYTES) begin
      mem[mem_q.addr] <= mem_q.data;
    end
  end
endmodule

// *** verif/fleuc_top_tb.sv ***
`timescale 1ns/1ps
module fleuc_top_tb;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, dbg_access = 0, bypass_en = 0;
  logic write_protect_opt = 0, read_protect_opt = 0, prog_req = 0, avs_waitrequest, core_stall;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [2:0] bypass_ctl = 0, bypass_pins;
  logic [15:0] prog_addr = 0;
  logic [7:0] prog_data = 0;
  fleuc_pkg::fleuc_mem_type mem_q;
  int err_total, checks_done, stall_cnt, s0;
  fleuc_top u_fleuc_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .dbg_access, .write_protect_opt, .read_protect_opt,
    .bypass_en, .bypass_ctl, .prog_req, .prog_addr, .prog_data, .mem_q, .core_stall,
    .bypass_pins);
  fleuc_flash_model u_fleuc_flash_model (.clk, .mem_q);
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) stall_cnt <= stall_cnt + int'(core_stall);
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 60);
    if (n == 60) chk("waitrequest", 0, 1);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task cmd(input logic [7:0] d); bus(1, fleuc_pkg::ADDR_CMD, {24'h0, d}); endtask
  task pg(input logic [31:0] d); bus(1, fleuc_pkg::ADDR_PAGE, d); endtask
  task st; bus(0, fleuc_pkg::ADDR_STATUS, 0); endtask
  task go(input logic [7:0] d); s0 = stall_cnt; cmd(d); endtask
  task unlock; cmd(8'h00); cmd(8'h73); cmd(8'h8C); endtask
  task automatic idle;
    int n = 0;
    do begin
      st();
      n++;
    end while (q[3:2] !== 2'b00 && n < 2000);
  endtask
  function automatic int ffs(int lo, int hi);
    int c = 0;
    for (int i = lo; i < hi; i++) c += int'(u_fleuc_flash_model.mem[i] === 8'hFF);
    return c;
  endfunction
  task s_basic;
    st();
    chk("status", 0, q);
    bus(0, 4'h2, 0);
    chk("unmapped", fleuc_pkg::UNMAPPED_DATA, q);
    bypass_en <= 1;
    bypass_ctl <= 3'h5;
    repeat (2) @(posedge clk);
    chk("pins", 3'h5, bypass_pins);
    bypass_en <= 0;
  endtask
  task s_order;
    cmd(8'h73);
    cmd(8'h00);
    st();
    chk("broken", 0, q[1:0]);
    cmd(8'h73);
    st();
    chk("first", 1, q[1:0]);
    cmd(8'h8C);
    st();
    chk("open", 3, q[1:0]);
  endtask
  task s_page;
    cmd(8'h00);
    pg(1);
    unlock();
    pg(1);
    go(8'h95);
    idle();
    chk("stall", 512, stall_cnt - s0);
    chk("page1", 512, ffs(512, 1024));
    chk("page0", 0, ffs(0, 512));
    chk("relock", 0, q[1:0]);
    go(8'h95);
    st();
    chk("reopen", 0, stall_cnt - s0);
    unlock();
    pg(1);
    prog_addr <= 16'h0205;
    prog_data <= 8'h5A;
    prog_req <= 1;
    @(posedge clk);
    prog_req <= 0;
    repeat (2) @(posedge clk);
    chk("prog", 8'h5A, u_fleuc_flash_model.mem[517]);
    cmd(8'h00);
  endtask
  task s_prot;
    bus(1, fleuc_pkg::ADDR_PROT, 4);
    bus(1, fleuc_pkg::ADDR_STATUS, 0);
    pg(2);
    unlock();
    pg(2);
    go(8'h95);
    st();
    chk("refused", 1, q[4]);
    chk("guarded", 0, stall_cnt - s0);
    dbg_access <= 1;
    write_protect_opt <= 1;
    unlock();
    pg(2);
    go(8'h95);
    idle();
    chk("dbg page", 512, ffs(1024, 1536));
    chk("dbg stall", 512, stall_cnt - s0);
    bus(1, fleuc_pkg::ADDR_PROT, 0);
    bus(0, fleuc_pkg::ADDR_PROT, 0);
    chk("prot", 0, q[3:0]);
  endtask
  task s_mass;
    dbg_access <= 0;
    unlock();
    go(8'h63);
    st();
    chk("mass nodbg", 0, stall_cnt - s0);
    dbg_access <= 1;
    read_protect_opt <= 1;
    unlock();
    pg(0);
    go(8'h95);
    st();
    chk("rp page", 0, stall_cnt - s0);
    unlock();
    go(8'h63);
    idle();
    chk("mass stall", 2048, stall_cnt - s0);
    chk("mass ff", 2048, ffs(0, 2048));
    chk("mass lock", 0, q[1:0]);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    s_basic();
    s_order();
    s_page();
    s_prot();
    s_mass();
    test_done();
  end
  initial begin
    #60000;
    err_total++;
    test_done();
  end
endmodule
bind fleuc_top fleuc_properties u_fleuc_properties (.clk, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .bypass_en, .bypass_ctl, .mem_q, .core_stall, .bypass_pins);
